/* File: logic/port_pkg.sv */
// port_pkg: shared constants and carrier types for the two parallel ports
// assumes: registers sit on a plain strobe port with byte-wide data
package port_pkg;
	localparam int PORT_W = 8;
	localparam int ADDR_W = 16;
	localparam logic [15:0] BUS_DIR_OFS = 16'hFFC4;
	localparam logic [15:0] BUS_DATA_OFS = 16'hFFC6;
	localparam logic [15:0] PULLUP_OFS = 16'hFFD8;
	localparam logic [15:0] ADDR_DIR_OFS = 16'hFFC1;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] WO_READ_VALUE = 8'hFF;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [2:0] MODE_MIN = 3'h1;
	localparam logic [2:0] MODE_MAX = 3'h7;
	localparam logic [2:0] MODE_SINGLE = 3'h7;
	localparam logic [2:0] MODE_PULLUP_MIN = 3'h5;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [PORT_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic [PORT_W-1:0] out;
		logic [PORT_W-1:0] oe;
	} pin_drive_s;
endpackage

/* File: logic/pin_sync.sv */
// pin_sync: three-stage synchroniser for a group of pin inputs
// assumes: pins are asynchronous to mclk; reset already synchronised
module pin_sync import port_pkg::*; #(
	parameter int WIDTH = 8
) (
	input wire logic mclk,
	input wire logic rstN,
	input wire logic [WIDTH-1:0] pinAsync,
	output logic [WIDTH-1:0] pinLevel
);
	logic [WIDTH-1:0] s1Q;
	logic [WIDTH-1:0] s2Q;
	logic [WIDTH-1:0] s3Q;

	// a zero-width group would leave the filter with no bit to watch
	if (WIDTH < 1) begin : g_widthCheck
		$error("pin_sync needs at least one pin");
	end

	// a bit changes only once stages two and three agree
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			s1Q <= '0;
			s2Q <= '0;
			s3Q <= '0;
			pinLevel <= '0;
		end else begin
			s1Q <= pinAsync;
			s2Q <= s1Q;
			s3Q <= s2Q;
			for (int i = 0; i < WIDTH; i++) begin
				if (s2Q[i] == s3Q[i]) begin
					pinLevel[i] <= s3Q[i];
				end
			end
		end
	end
endmodule

/* File: logic/parallel_port.sv */
// parallel_port: pull-up gating of the address port and the data bus port
// assumes: mode pins are static; standby inputs come from the mclk domain
// ****************************************************************
// register bus, pins and standby
// ****************************************************************

// What this block does
// - 8-bit read/write pull-up enable register for the address port
// - modes 5-7: pull-up on only when direction bit 0 and enable 1
// - modes 1-4: all address port pull-ups stay off
// - modes 5-7: pull-ups off in reset and hardware standby
// - pull-up enable clears on reset and hardware standby, kept in sw standby
// - modes 1-6: bus port carries the data bus; direction used only by the port read
// - mode 7: bus pin outputs when direction bit 1, input when 0
// - bus direction register is write-only and reads back all ones
// - bus direction clears on reset and hardware standby, kept in sw standby
// - software standby: output pins keep their driven state
// - data register holds output data, driven while a pin is output
// - port read gives register bit for outputs, pin level for inputs
// - data register clears on reset and hardware standby, kept in sw standby
// - modes 5-6: address pin is address output when direction bit 1
module parallel_port import port_pkg::*; (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [2:0] opMode,
	input wire logic hwStandby,
	input wire logic swStandby,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [PORT_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [PORT_W-1:0] regRdata,
	input wire logic [PORT_W-1:0] addrPortDirection,
	output logic [PORT_W-1:0] addrPullupOn,
	output logic [PORT_W-1:0] addrOutSelect,
	input wire logic [PORT_W-1:0] busPinIn,
	output logic [PORT_W-1:0] busPinOut,
	output logic [PORT_W-1:0] busPinOe,
	output logic busPortExternal
);
	// ****************************************************************
	// reset release and pin synchronisation
	// ****************************************************************
	logic rstMetaQ;
	logic rstN;
	reg_req_s req;
	pin_drive_s busDrive;
	logic [PORT_W-1:0] busPinLevel;
	logic [PORT_W-1:0] pullupEnable_q;
	logic [PORT_W-1:0] busDirection_q;
	logic [PORT_W-1:0] busData_q;
	logic [PORT_W-1:0] readData_d;
	logic singleChip;
	logic pullupMode;
	logic addrOutMode;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rstMetaQ <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMetaQ <= 1'b1;
			rstN <= rstMetaQ;
		end
	end

	pin_sync #(.WIDTH(PORT_W)) busSync (
		.mclk(mclk),
		.rstN(rstN),
		.pinAsync(busPinIn),
		.pinLevel(busPinLevel)
	);

	assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

	// mode decode is pure combinational logic on a static strap
	assign singleChip = (opMode == MODE_SINGLE);
	assign pullupMode = (opMode >= MODE_PULLUP_MIN);
	assign addrOutMode = pullupMode && !singleChip;

	// ****************************************************************
	// registers
	// ****************************************************************
	// hardware standby acts like reset; software standby simply holds
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			pullupEnable_q <= REG_RESET;
		end else if (hwStandby) begin
			pullupEnable_q <= REG_RESET;
		end else if (req.wr && req.addr == PULLUP_OFS) begin
			pullupEnable_q <= req.wdata;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			busDirection_q <= REG_RESET;
		end else if (hwStandby) begin
			busDirection_q <= REG_RESET;
		end else if (req.wr && req.addr == BUS_DIR_OFS) begin
			busDirection_q <= req.wdata;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			busData_q <= REG_RESET;
		end else if (hwStandby) begin
			busData_q <= REG_RESET;
		end else if (req.wr && req.addr == BUS_DATA_OFS) begin
			busData_q <= req.wdata;
		end
	end

	always_comb begin
		readData_d = UNMAPPED_READ;
		unique case (req.addr)
			BUS_DIR_OFS: readData_d = WO_READ_VALUE;
			BUS_DATA_OFS: readData_d = (busData_q & busDirection_q)
				| (busPinLevel & ~busDirection_q);
			PULLUP_OFS: readData_d = pullupEnable_q;
			default: readData_d = UNMAPPED_READ;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			regRdata <= '0;
		end else if (req.rd) begin
			regRdata <= readData_d;
		end else begin
			regRdata <= '0;
		end
	end

	// ****************************************************************
	// pin control
	// ****************************************************************
	// external bus owns the pins in modes 1-6, so oe is left to it
	assign busDrive.oe = singleChip ? busDirection_q : '0;
	assign busDrive.out = busData_q;

	// registers hold in software standby, so outputs keep their state
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			busPinOut <= '0;
			busPinOe <= '0;
			busPortExternal <= 1'b0;
		end else if (hwStandby) begin
			busPinOut <= '0;
			busPinOe <= '0;
			busPortExternal <= 1'b0;
		end else begin
			busPinOut <= busDrive.out;
			busPinOe <= busDrive.oe;
			busPortExternal <= !singleChip;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			addrPullupOn <= '0;
			addrOutSelect <= '0;
		end else if (hwStandby) begin
			addrPullupOn <= '0;
			addrOutSelect <= '0;
		end else begin
			addrPullupOn <= pullupMode
				? (pullupEnable_q & ~addrPortDirection) : '0;
			addrOutSelect <= addrOutMode ? addrPortDirection : '0;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_pullupLow;
		@(posedge mclk) disable iff (!rstN)
		(!pullupMode) |=> (addrPullupOn == '0);
	endproperty
	a_pullupLow: assert property (p_pullupLow)
		else $error("pull-up on in modes 1-4");

	property p_pullupGate;
		@(posedge mclk) disable iff (!rstN)
		(pullupMode && !hwStandby) |=>
			(addrPullupOn == ($past(pullupEnable_q) &
			~$past(addrPortDirection)));
	endproperty
	a_pullupGate: assert property (p_pullupGate)
		else $error("pull-up gating wrong");

	property p_hwStandbyOff;
		@(posedge mclk) disable iff (!rstN)
		hwStandby |=> (addrPullupOn == '0 && pullupEnable_q == '0);
	endproperty
	a_hwStandbyOff: assert property (p_hwStandbyOff)
		else $error("pull-up not off in hardware standby");

	property p_pullupKeep;
		@(posedge mclk) disable iff (!rstN)
		(swStandby && !hwStandby && !req.wr) |=> $stable(pullupEnable_q);
	endproperty
	a_pullupKeep: assert property (p_pullupKeep)
		else $error("pull-up enable lost in software standby");

	property p_dirReadOnes;
		@(posedge mclk) disable iff (!rstN)
		(req.rd && req.addr == BUS_DIR_OFS) |=> (regRdata == WO_READ_VALUE);
	endproperty
	a_dirReadOnes: assert property (p_dirReadOnes)
		else $error("direction read not all ones");

	property p_busExternal;
		@(posedge mclk) disable iff (!rstN)
		(!singleChip && !hwStandby) |=> (busPinOe == '0 && busPortExternal);
	endproperty
	a_busExternal: assert property (p_busExternal)
		else $error("bus port driven by port logic in expanded mode");

	property p_singleOe;
		@(posedge mclk) disable iff (!rstN)
		(singleChip && !hwStandby) |=> (busPinOe == $past(busDirection_q));
	endproperty
	a_singleOe: assert property (p_singleOe)
		else $error("output enable does not follow direction");

	property p_dataRead;
		@(posedge mclk) disable iff (!rstN)
		(req.rd && req.addr == BUS_DATA_OFS) |=>
			(regRdata == (($past(busData_q) & $past(busDirection_q)) |
			($past(busPinLevel) & ~$past(busDirection_q))));
	endproperty
	a_dataRead: assert property (p_dataRead)
		else $error("port read mixes wrong sources");

	property p_dataWrite;
		@(posedge mclk) disable iff (!rstN)
		(req.wr && req.addr == BUS_DATA_OFS && !hwStandby) |=>
			(busData_q == $past(req.wdata)) ##1 (busPinOut == $past(busData_q));
	endproperty
	a_dataWrite: assert property (p_dataWrite)
		else $error("data register not driven to pins");

	property p_swHold;
		@(posedge mclk) disable iff (!rstN)
		(swStandby && !hwStandby && !req.wr) ##1 (swStandby && !hwStandby)
			|-> $stable(busPinOut) && $stable(busPinOe);
	endproperty
	a_swHold: assert property (p_swHold)
		else $error("outputs changed in software standby");

	property p_hwClear;
		@(posedge mclk) disable iff (!rstN)
		hwStandby |=> (busData_q == '0 && busDirection_q == '0);
	endproperty
	a_hwClear: assert property (p_hwClear)
		else $error("bus port registers not cleared");

	property p_pullupWrite;
		@(posedge mclk) disable iff (!rstN)
		(req.wr && req.addr == PULLUP_OFS && !hwStandby) |=>
			(pullupEnable_q == $past(req.wdata));
	endproperty
	a_pullupWrite: assert property (p_pullupWrite)
		else $error("pull-up enable write lost");

	property p_dirWrite;
		@(posedge mclk) disable iff (!rstN)
		(req.wr && req.addr == BUS_DIR_OFS && !hwStandby) |=>
			(busDirection_q == $past(req.wdata));
	endproperty
	a_dirWrite: assert property (p_dirWrite)
		else $error("direction write lost");

	// software standby must not disturb the bus port registers
	property p_dirKeep;
		@(posedge mclk) disable iff (!rstN)
		(swStandby && !hwStandby && !req.wr) |=>
			$stable(busDirection_q);
	endproperty
	a_dirKeep: assert property (p_dirKeep)
		else $error("direction lost in software standby");

	property p_dataKeep;
		@(posedge mclk) disable iff (!rstN)
		(swStandby && !hwStandby && !req.wr) |=> $stable(busData_q);
	endproperty
	a_dataKeep: assert property (p_dataKeep)
		else $error("data register lost in software standby");

	property p_addrOut;
		@(posedge mclk) disable iff (!rstN)
		(addrOutMode && !hwStandby) |=>
			(addrOutSelect == $past(addrPortDirection));
	endproperty
	a_addrOut: assert property (p_addrOut)
		else $error("address select does not follow direction");

	property p_addrOutOff;
		@(posedge mclk) disable iff (!rstN)
		(!addrOutMode) |=> (addrOutSelect == '0);
	endproperty
	a_addrOutOff: assert property (p_addrOutOff)
		else $error("address output selected outside modes 5-6");

	// read data must drop back to zero so stale bytes never linger
	property p_rdataIdle;
		@(posedge mclk) disable iff (!rstN)
		(!req.rd) |=> (regRdata == '0);
	endproperty
	a_rdataIdle: assert property (p_rdataIdle)
		else $error("read data held past its cycle");
endmodule

/* File: tb/parallel_port_tb.sv */
// parallel_port_tb: self-checking bench for the two parallel ports
// assumes: port_pkg and logic/ files compiled first; one 10 MHz clock
module parallel_port_tb import port_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0] m;
		logic [7:0] ad, pu, bd, dat, pin, xPu, xSel, xOe, xOut, xRd;
		logic xExt;
	} row_s;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] opMode = 3'h7;
	logic hwStandby = 1'b0;
	logic swStandby = 1'b0;
	logic [15:0] regAddr = 16'h0000;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] addrPortDirection = 8'h00;
	logic [7:0] busPinIn = 8'h00;
	logic [7:0] regRdata, addrPullupOn, addrOutSelect, busPinOut, busPinOe;
	logic busPortExternal;
	int errors = 0;
	int n_checks = 0;
	row_s r;
	// ****************************************************************
	// one row per mode: inputs, then the outputs they should give
	// ****************************************************************
	row_s rows [0:6] = '{
		'{3'h1, 8'h0F, 8'hFF, 8'hFF, 8'hA5, 8'h3C,
			8'h00, 8'h00, 8'h00, 8'h00, 8'hA5, 1'b1},
		'{3'h2, 8'hFF, 8'h01, 8'h01, 8'h01, 8'hFE,
			8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 1'b1},
		'{3'h3, 8'h00, 8'h80, 8'h80, 8'h00, 8'h7F,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 1'b1},
		'{3'h4, 8'h00, 8'h55, 8'h0F, 8'h5A, 8'hC3,
			8'h00, 8'h00, 8'h00, 8'h00, 8'hCA, 1'b1},
		'{3'h5, 8'h0F, 8'h33, 8'hF0, 8'h96, 8'h69,
			8'h30, 8'h0F, 8'h00, 8'h00, 8'h99, 1'b1},
		'{3'h6, 8'hF0, 8'hFF, 8'h00, 8'hFF, 8'h00,
			8'h0F, 8'hF0, 8'h00, 8'h00, 8'h00, 1'b1},
		'{3'h7, 8'h81, 8'hC3, 8'h3C, 8'h5A, 8'hA5,
			8'h42, 8'h00, 8'h3C, 8'h18, 8'h99, 1'b0}
	};

	parallel_port dut (
		.mclk(mclk), .reset_n(reset_n), .opMode(opMode),
		.hwStandby(hwStandby), .swStandby(swStandby),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata),
		.addrPortDirection(addrPortDirection),
		.addrPullupOn(addrPullupOn), .addrOutSelect(addrOutSelect),
		.busPinIn(busPinIn), .busPinOut(busPinOut), .busPinOe(busPinOe),
		.busPortExternal(busPortExternal)
	);

	initial begin
		forever #50 mclk = ~mclk;
	end

	task automatic wrap_up;
		if (errors == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// mode only changes under reset, since the block treats it as static
	task automatic start(input logic [2:0] m);
		@(posedge mclk);
		reset_n <= 1'b0;
		opMode <= m;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		chk(regRdata, e);
	endtask

	// covers the pin synchroniser latency plus the output register
	task automatic settle;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		wrap_up();
	end

	initial begin
		for (int i = 0; i < 7; i++) begin
			r = rows[i];
			start(r.m);
			addrPortDirection <= r.ad;
			busPinIn <= r.pin;
			wr(PULLUP_OFS, r.pu);
			wr(BUS_DIR_OFS, r.bd);
			wr(BUS_DATA_OFS, r.dat);
			settle();
			chk(addrPullupOn, r.xPu);
			chk(addrOutSelect, r.xSel);
			chk(busPinOe, r.xOe);
			chk(busPinOut & busPinOe, r.xOut);
			chk({7'h00, busPortExternal}, {7'h00, r.xExt});
			rdc(BUS_DATA_OFS, r.xRd);
			rdc(PULLUP_OFS, r.pu);
			rdc(BUS_DIR_OFS, WO_READ_VALUE);
		end
		@(posedge mclk);
		swStandby <= 1'b1;
		settle();
		chk(busPinOe, 8'h3C);
		chk(busPinOut & busPinOe, 8'h18);
		chk(addrPullupOn, 8'h42);
		rdc(PULLUP_OFS, 8'hC3);
		@(posedge mclk);
		swStandby <= 1'b0;
		wr(16'hFFC5, 8'hAA);
		rdc(16'hFFC5, UNMAPPED_READ);
		rdc(BUS_DATA_OFS, 8'h99);
		wr(BUS_DIR_OFS, 8'hFF);
		@(posedge mclk);
		busPinIn <= 8'h0F;
		wr(BUS_DATA_OFS, 8'h55);
		wr(PULLUP_OFS, 8'hFF);
		settle();
		chk(busPinOe, 8'hFF);
		rdc(BUS_DATA_OFS, 8'h55);
		@(posedge mclk);
		hwStandby <= 1'b1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk(addrPullupOn, 8'h00);
		chk(busPinOe, 8'h00);
		@(posedge mclk);
		hwStandby <= 1'b0;
		rdc(PULLUP_OFS, REG_RESET);
		rdc(BUS_DATA_OFS, 8'h0F);
		wr(BUS_DIR_OFS, 8'hFF);
		rdc(BUS_DATA_OFS, REG_RESET);
		wr(PULLUP_OFS, 8'hFF);
		settle();
		chk(addrPullupOn, 8'h7E);
		@(posedge mclk);
		reset_n <= 1'b0;
		@(negedge mclk);
		chk(addrPullupOn, 8'h00);
		@(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rdc(PULLUP_OFS, REG_RESET);
		wrap_up();
	end
endmodule
